// >>> bench/fomc_option_control_test.sv
// self-checking bench for the ring option control block
`timescale 1ns/1ps
module fomc_option_control_test;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic opt_wr = 1'b0;
   logic [7:0] opt_wdata = 8'h00;
   logic claim_req_set = 1'b0;
   logic tx_short_addr_frame = 1'b0;
   fomc_pkg::fomc_rx_evt_t rx_evt = '0;
   fomc_pkg::fomc_tx_req_t tx_req = '0;
   fomc_pkg::fomc_frame_t frame;
   logic go = 1'b0;
   logic [1:0] fmt = 2'h0;
   logic crc_ok = 1'b0;
   logic ext_a = 1'b0;
   logic ext_c = 1'b0;
   logic ea, vc, use_long_addr, tx_frame_permit, strip_all, mac_reset_req;
   logic claim_req, tx_error_ind, tx_addr_recognized_ind, tx_copied_ind;
   logic [7:0] ring_option_control;
   logic [15:0] error_indicator_counter, copied_count, not_copied_count;
   fomc_pkg::fomc_tx_state_t claim_tx_state;
   logic seen_e, seen_a, seen_c, seen_rst, seen_dv, seen_rep, seen_tok;
   int err_count = 0;
   int samples_checked = 0;

   always #12.5 ref_clk = ~ref_clk;

   fomc_option_control DUT (.ref_clk(ref_clk), .rst(rst), .opt_wr(opt_wr),
      .opt_wdata(opt_wdata), .ring_option_control(ring_option_control),
      .claim_req_set(claim_req_set), .claim_req(claim_req),
      .rx_evt(rx_evt), .tx_req(tx_req),
      .tx_short_addr_frame(tx_short_addr_frame), .frame(frame),
      .external_addr_match_in(ea), .external_copy_valid_in(vc),
      .claim_tx_state(claim_tx_state), .use_long_addr(use_long_addr),
      .tx_frame_permit(tx_frame_permit), .strip_all(strip_all),
      .mac_reset_req(mac_reset_req), .tx_error_ind(tx_error_ind),
      .tx_addr_recognized_ind(tx_addr_recognized_ind),
      .tx_copied_ind(tx_copied_ind),
      .error_indicator_counter(error_indicator_counter),
      .copied_count(copied_count), .not_copied_count(not_copied_count));

   fomc_ring_model ring (.ref_clk(ref_clk), .go(go), .fmt(fmt),
      .crc_ok(crc_ok), .ext_a(ext_a), .ext_c(ext_c), .frame(frame),
      .external_addr_match_in(ea), .external_copy_valid_in(vc));

   // one-cycle outputs are caught here so scenarios can judge them later
   always @(posedge ref_clk) begin
      if (tx_error_ind === 1'b1) seen_e <= 1'b1;
      if (tx_addr_recognized_ind === 1'b1) seen_a <= 1'b1;
      if (tx_copied_ind === 1'b1) seen_c <= 1'b1;
      if (mac_reset_req === 1'b1) seen_rst <= 1'b1;
      if (claim_tx_state === fomc_pkg::TX_DATA) seen_dv <= 1'b1;
      if (claim_tx_state === fomc_pkg::TX_VOID) seen_dv <= 1'b1;
      if (claim_tx_state === fomc_pkg::TX_REPEAT) seen_rep <= 1'b1;
      if (claim_tx_state === fomc_pkg::TX_ISSUE_TOKEN) seen_tok <= 1'b1;
   end

   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk

   task automatic st(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : st

   task automatic do_reset();
      @(negedge ref_clk);
      rst = 1'b1;
      rx_evt = '0;
      tx_req = '0;
      tx_short_addr_frame = 1'b0;
      st(4);
      rst = 1'b0;
      {seen_e, seen_a, seen_c, seen_rst, seen_dv, seen_rep, seen_tok} = '0;
   endtask : do_reset

   task automatic wr(input logic [7:0] v);
      opt_wr = 1'b1;
      opt_wdata = v;
      st(1);
      opt_wr = 1'b0;
      st(3);
   endtask : wr

   task automatic send(input logic [1:0] f, input logic c, a, v);
      fmt = f;
      crc_ok = c;
      ext_a = a;
      ext_c = v;
      go = 1'b1;
      st(1);
      go = 1'b0;
      st(18);
   endtask : send

   task automatic t_regs();
      logic [7:0] v [3] = '{8'h01, 8'h02, 8'h03};
      do_reset();
      chk(ring_option_control === fomc_pkg::OPTION_RESET, "reset");
      chk(claim_tx_state === fomc_pkg::TX_IDLE, "reset state");
      wr(8'ha5);
      chk(ring_option_control === 8'ha5, "readback");
      foreach (v[i]) begin
         wr(v[i]);
         chk(use_long_addr === v[i][1], "claim address width");
      end
      tx_short_addr_frame = 1'b1;
      wr(8'h02);
      chk(tx_frame_permit === 1'b0, "short frame allowed");
      tx_req.sa_transparency = 1'b1;
      st(3);
      chk(tx_frame_permit === 1'b1, "transparent short refused");
      tx_req.sa_transparency = 1'b0;
      wr(8'h01);
      chk(tx_frame_permit === 1'b1, "short frame refused");
      tx_short_addr_frame = 1'b0;
      tx_req.immediate_req = 1'b1;
      wr(8'h00);
      chk(tx_frame_permit === 1'b0, "isolated immediate sent");
      tx_req.sa_transparency = 1'b1;
      st(3);
      chk(tx_frame_permit === 1'b1, "transparent immediate held");
      tx_req = '0;
      $display("test regs done");
   endtask : t_regs

   task automatic t_claim();
      do_reset();
      rx_evt.recovery_required = 1'b1;
      tx_req.token_usable = 1'b1;
      tx_req.data_pending = 1'b1;
      st(10);
      chk(claim_tx_state === fomc_pkg::TX_IDLE, "isolated moved");
      chk(seen_dv === 1'b0, "isolated captured");
      tx_req = '0;
      wr(8'h0b);
      st(6);
      chk(claim_tx_state === fomc_pkg::TX_IDLE, "recovery claim");
      claim_req_set = 1'b1;
      st(1);
      claim_req_set = 1'b0;
      st(6);
      chk(claim_tx_state === fomc_pkg::TX_CLAIM, "no sw claim");
      chk(claim_req === 1'b0, "claim request kept");
      rx_evt.recovery_required = 1'b0;
      wr(8'h0f);
      rx_evt.my_claim_won = 1'b1;
      st(1);
      rx_evt.my_claim_won = 1'b0;
      st(8);
      chk(claim_tx_state === fomc_pkg::TX_CLAIM, "left claim");
      chk(seen_tok === 1'b0, "token issued");
      rx_evt.higher_claim_rx = 1'b1;
      st(1);
      rx_evt.higher_claim_rx = 1'b0;
      st(6);
      chk(claim_tx_state !== fomc_pkg::TX_CLAIM, "stuck in claim");
      $display("test claim done");
   endtask : t_claim

   task automatic t_capture();
      do_reset();
      wr(8'h83);
      tx_req.token_usable = 1'b1;
      tx_req.data_pending = 1'b1;
      tx_req.void_wanted = 1'b1;
      st(10);
      chk(seen_dv === 1'b0, "captured while inhibited");
      wr(8'h03);
      st(10);
      chk(seen_dv === 1'b1, "no capture once allowed");
      $display("test capture done");
   endtask : t_capture

   task automatic t_repeat();
      do_reset();
      rx_evt.ring_operational = 1'b1;
      wr(8'h13);
      st(6);
      chk(strip_all === 1'b1, "not stripping");
      chk(seen_rst === 1'b1, "no reset action");
      rx_evt.token_rx = 1'b1;
      rx_evt.mac_frame_rx = 1'b1;
      st(2);
      rx_evt = '0;
      st(8);
      chk(seen_rep === 1'b0, "repeated");
      chk(seen_tok === 1'b0, "token issued");
      $display("test repeat done");
   endtask : t_repeat

   task automatic t_frames();
      do_reset();
      wr(8'h03);
      send(fomc_pkg::FF_IMPLEMENTER, 1'b0, 1'b1, 1'b1);
      chk(error_indicator_counter === 16'h0000, "counted unchecked");
      chk(seen_a === 1'b0, "ext match used");
      chk(seen_e === 1'b0, "error ind set unchecked");
      wr(8'h23);
      send(fomc_pkg::FF_IMPLEMENTER, 1'b0, 1'b0, 1'b0);
      chk(error_indicator_counter === 16'h0001, "error count");
      chk(seen_e === 1'b1, "error ind not S");
      send(fomc_pkg::FF_IMPLEMENTER, 1'b1, 1'b0, 1'b0);
      chk(error_indicator_counter === 16'h0001, "good frame counted");
      wr(8'h43);
      send(2'h1, 1'b1, 1'b1, 1'b1);
      chk(seen_a === 1'b1, "addr ind not S");
      chk(seen_c === 1'b1, "copied ind not S");
      chk(copied_count === 16'h0001, "copied count");
      send(2'h1, 1'b1, 1'b1, 1'b0);
      chk(not_copied_count === 16'h0001, "not copied count");
      $display("test frames done");
   endtask : t_frames

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   initial begin
      t_regs();
      t_claim();
      t_capture();
      t_repeat();
      t_frames();
      complete_run();
   end

   // the tests need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge ref_clk);
      err_count++;
      complete_run();
   end
endmodule : fomc_option_control_test

// >>> bench/fomc_ring_model.sv
// ring side model: frame status and external match pins for one frame
`timescale 1ns/1ps
module fomc_ring_model (
   input wire logic ref_clk,
   input wire logic go,
   input wire logic [1:0] fmt,
   input wire logic crc_ok,
   input wire logic ext_a,
   input wire logic ext_c,
   output fomc_pkg::fomc_frame_t frame,
   output logic external_addr_match_in,
   output logic external_copy_valid_in
);
   logic [3:0] cnt = 4'h0;
   always @(posedge ref_clk) begin
      if (go) begin
         cnt <= 4'h1;
      end else if (cnt != 4'h0) begin
         cnt <= cnt + 4'h1;
      end
   end
   // pins lead the frame end so the pin synchronizer has caught up
   always_comb begin
      external_addr_match_in = (cnt != 4'h0) && ext_a;
      external_copy_valid_in = (cnt != 4'h0) && ext_c;
      frame.frame_end = (cnt == 4'h6);
      // outside the end pulse the fields carry junk, not the last value
      frame.frame_format_bits = frame.frame_end ? fmt : ~fmt;
      frame.crc_good = frame.frame_end ? crc_ok : ~crc_ok;
      frame.rx_error_ind = 1'b0;
      frame.internal_match = 1'b0;
      frame.internal_copied = 1'b0;
   end
endmodule : fomc_ring_model

// >>> core/fomc_counter.sv
// saturating-free wrapping statistics counter with registered value
`timescale 1ns/1ps
module fomc_counter #(
   parameter int WIDTH = 16
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic inc,
   output logic [WIDTH-1:0] count
);
   logic [WIDTH-1:0] next_count;

   always_comb begin
      next_count = count;
      if (inc) begin
         next_count = count + WIDTH'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end
endmodule : fomc_counter

// >>> core/fomc_option_control.sv
// option register and option-gated transmitter/receiver decisions
`timescale 1ns/1ps
module fomc_option_control (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic opt_wr,
   input wire logic [7:0] opt_wdata,
   output logic [7:0] ring_option_control,
   input wire logic claim_req_set,
   output logic claim_req,
   input wire fomc_pkg::fomc_rx_evt_t rx_evt,
   input wire fomc_pkg::fomc_tx_req_t tx_req,
   input wire logic tx_short_addr_frame,
   input wire fomc_pkg::fomc_frame_t frame,
   input wire logic external_addr_match_in,
   input wire logic external_copy_valid_in,
   output fomc_pkg::fomc_tx_state_t claim_tx_state,
   output logic use_long_addr,
   output logic tx_frame_permit,
   output logic strip_all,
   output logic mac_reset_req,
   output logic tx_error_ind,
   output logic tx_addr_recognized_ind,
   output logic tx_copied_ind,
   output logic [15:0] error_indicator_counter,
   output logic [15:0] copied_count,
   output logic [15:0] not_copied_count
);
   logic [7:0] next_option;
   logic next_claim_req;
   fomc_pkg::fomc_tx_state_t next_state;
   logic next_use_long, next_permit, next_strip, next_reset_req;
   logic next_err, next_a, next_c;
   logic ea_s1, ea_s2, ea_s3, ea_lvl, next_ea_lvl;
   logic cv_s1, cv_s2, cv_s3, cv_lvl, next_cv_lvl;
   logic inc_err, inc_cop, inc_ncop;
   logic reset_pending, next_reset_pending;

   // option bit helper
   function automatic logic opt(input logic [7:0] r, input int b);
      return r[b];
   endfunction : opt

   logic o_sa, o_la, o_tri, o_rri, o_rpi, o_crc, o_em, o_tci, isolated;
   always_comb begin
      o_sa = opt(ring_option_control, fomc_pkg::OPT_SHORT_ADDR);
      o_la = opt(ring_option_control, fomc_pkg::OPT_LONG_ADDR);
      o_tri = opt(ring_option_control, fomc_pkg::OPT_TOKEN_REL_INH);
      o_rri = opt(ring_option_control, fomc_pkg::OPT_RECOVERY_INH);
      o_rpi = opt(ring_option_control, fomc_pkg::OPT_REPEAT_INH);
      o_crc = opt(ring_option_control, fomc_pkg::OPT_IMPL_CRC);
      o_em = opt(ring_option_control, fomc_pkg::OPT_EXT_MATCH);
      o_tci = opt(ring_option_control, fomc_pkg::OPT_TOKEN_CAP_INH);
      isolated = !o_sa && !o_la;
   end

   // option register and claim request flag
   always_comb begin
      next_option = ring_option_control;
      if (opt_wr) begin
         next_option = opt_wdata;
      end
      next_claim_req = claim_req;
      // completion clears, but a new request in the same cycle wins
      if (claim_req && claim_tx_state == fomc_pkg::TX_CLAIM) begin
         next_claim_req = 1'b0;
      end
      if (claim_req_set) begin
         next_claim_req = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ring_option_control <= fomc_pkg::OPTION_RESET;
         claim_req <= 1'b0;
      end else begin
         ring_option_control <= next_option;
         claim_req <= next_claim_req;
      end
   end

   // external pins: three stages, change taken when last two agree
   always_comb begin
      next_ea_lvl = ea_lvl;
      if (ea_s2 == ea_s3) begin
         next_ea_lvl = ea_s3;
      end
      next_cv_lvl = cv_lvl;
      if (cv_s2 == cv_s3) begin
         next_cv_lvl = cv_s3;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {ea_s1, ea_s2, ea_s3, ea_lvl} <= 4'h0;
         {cv_s1, cv_s2, cv_s3, cv_lvl} <= 4'h0;
      end else begin
         ea_s1 <= external_addr_match_in;
         ea_s2 <= ea_s1;
         ea_s3 <= ea_s2;
         ea_lvl <= next_ea_lvl;
         cv_s1 <= external_copy_valid_in;
         cv_s2 <= cv_s1;
         cv_s3 <= cv_s2;
         cv_lvl <= next_cv_lvl;
      end
   end

   // transmitter decisions
   logic recov_ok, imm_ok, rx_claim_evt, token_in;
   always_comb begin
      next_state = claim_tx_state;
      next_reset_pending = reset_pending;
      next_reset_req = 1'b0;
      // isolation suspends recovery; recovery inhibit masks it too
      recov_ok = rx_evt.recovery_required && !o_rri && !isolated;
      // lower claim / my beacon still count under repeat inhibit
      rx_claim_evt = (rx_evt.lower_claim_rx || rx_evt.my_beacon_rx)
                     && !o_rri;
      imm_ok = tx_req.immediate_req
               && (!isolated || tx_req.sa_transparency);
      // repeat inhibit drops received tokens
      token_in = tx_req.token_usable && !o_rpi && !isolated;
      case (claim_tx_state)
         fomc_pkg::TX_IDLE: begin
            if (claim_req) begin
               next_state = fomc_pkg::TX_CLAIM;
            end else if (recov_ok || (rx_claim_evt && !isolated)) begin
               next_state = fomc_pkg::TX_CLAIM;
            end else if (reset_pending) begin
               next_reset_req = 1'b1;
               next_reset_pending = 1'b0;
            end else if (token_in && !o_tci) begin
               if (tx_req.data_pending) begin
                  next_state = fomc_pkg::TX_DATA;
               end else if (tx_req.void_wanted) begin
                  next_state = fomc_pkg::TX_VOID;
               end
            end else if (!o_rpi && !isolated && rx_evt.token_rx) begin
               next_state = fomc_pkg::TX_REPEAT;
            end
         end
         fomc_pkg::TX_REPEAT: begin
            if (o_rpi || isolated || tx_req.frame_done) begin
               next_state = fomc_pkg::TX_IDLE;
            end
         end
         fomc_pkg::TX_DATA: begin
            // capture inhibit lets the frame on the wire finish first
            if (tx_req.frame_done && (o_tci || tx_req.opportunity_done))
            begin
               if (o_rpi) begin
                  next_state = fomc_pkg::TX_IDLE;
               end else begin
                  next_state = fomc_pkg::TX_ISSUE_TOKEN;
               end
            end
         end
         fomc_pkg::TX_VOID: begin
            if (o_rpi || tx_req.frame_done) begin
               next_state = fomc_pkg::TX_IDLE;
            end
         end
         fomc_pkg::TX_ISSUE_TOKEN: begin
            if (o_rpi || tx_req.frame_done) begin
               next_state = fomc_pkg::TX_IDLE;
            end
         end
         fomc_pkg::TX_CLAIM: begin
            if (rx_evt.beacon_rx) begin
               next_state = fomc_pkg::TX_BEACON;
            end else if (rx_evt.higher_claim_rx) begin
               next_state = fomc_pkg::TX_IDLE;
            end else if (rx_evt.my_claim_won && !o_tri && !o_rpi) begin
               next_state = fomc_pkg::TX_ISSUE_TOKEN;
            end
         end
         fomc_pkg::TX_BEACON: begin
            if (rx_evt.ring_operational || tx_req.immediate_done) begin
               next_state = fomc_pkg::TX_IDLE;
            end
         end
         default: begin
            next_state = fomc_pkg::TX_IDLE;
         end
      endcase
      // only the enabling write arms it, so the reset fires once; set wins
      if (opt_wr && opt_wdata[fomc_pkg::OPT_REPEAT_INH] && !o_rpi
          && rx_evt.ring_operational) begin
         next_reset_pending = 1'b1;
      end
      next_use_long = o_la;
      // immediate transmissions barred from data state when inhibited
      next_permit = (!tx_short_addr_frame || o_sa
                     || tx_req.sa_transparency)
                    && (!tx_req.immediate_req || imm_ok)
                    && !(tx_req.immediate_req && o_tci
                         && claim_tx_state == fomc_pkg::TX_DATA);
      next_strip = o_rpi || isolated;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         claim_tx_state <= fomc_pkg::TX_IDLE;
         reset_pending <= 1'b0;
         mac_reset_req <= 1'b0;
         use_long_addr <= 1'b0;
         tx_frame_permit <= 1'b0;
         strip_all <= 1'b0;
      end else begin
         claim_tx_state <= next_state;
         reset_pending <= next_reset_pending;
         mac_reset_req <= next_reset_req;
         use_long_addr <= next_use_long;
         tx_frame_permit <= next_permit;
         strip_all <= next_strip;
      end
   end

   // frame status indicators and counting
   logic impl_fr, ext_hit, matched;
   always_comb begin
      impl_fr = frame.frame_format_bits == fomc_pkg::FF_IMPLEMENTER;
      ext_hit = o_em && ea_lvl;
      matched = frame.internal_match || ext_hit;
      next_err = frame.rx_error_ind;
      inc_err = 1'b0;
      if (frame.frame_end && impl_fr && o_crc && !frame.crc_good
          && !frame.rx_error_ind) begin
         next_err = 1'b1;
         inc_err = 1'b1;
      end
      next_a = frame.internal_match || ext_hit;
      next_c = frame.internal_copied || (ext_hit && cv_lvl);
      inc_cop = frame.frame_end && matched && next_c;
      inc_ncop = frame.frame_end && matched && !next_c;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_error_ind <= 1'b0;
         tx_addr_recognized_ind <= 1'b0;
         tx_copied_ind <= 1'b0;
      end else begin
         tx_error_ind <= next_err;
         tx_addr_recognized_ind <= next_a;
         tx_copied_ind <= next_c;
      end
   end

   fomc_counter #(.WIDTH(16)) u_err_cnt (.ref_clk(ref_clk), .rst(rst),
      .inc(inc_err), .count(error_indicator_counter));
   fomc_counter #(.WIDTH(16)) u_cop_cnt (.ref_clk(ref_clk), .rst(rst),
      .inc(inc_cop), .count(copied_count));
   fomc_counter #(.WIDTH(16)) u_ncop_cnt (.ref_clk(ref_clk), .rst(rst),
      .inc(inc_ncop), .count(not_copied_count));

   // assertions
   token_rel_inh_a: assert property (@(posedge ref_clk) disable iff (rst)
      (claim_tx_state == fomc_pkg::TX_CLAIM && o_tri)
      |=> claim_tx_state != fomc_pkg::TX_ISSUE_TOKEN)
      else $error("token issued after claim with release inhibited");
   repeat_inh_a: assert property (@(posedge ref_clk) disable iff (rst)
      (o_rpi && !opt_wr) |=> (claim_tx_state != fomc_pkg::TX_REPEAT
      && !$rose(claim_tx_state == fomc_pkg::TX_ISSUE_TOKEN)))
      else $error("repeat or token entered with repeat inhibited");
   cap_inh_a: assert property (@(posedge ref_clk) disable iff (rst)
      (claim_tx_state == fomc_pkg::TX_IDLE && o_tci)
      |=> claim_tx_state != fomc_pkg::TX_DATA
          && claim_tx_state != fomc_pkg::TX_VOID)
      else $error("token captured while inhibited");
   sw_claim_a: assert property (@(posedge ref_clk) disable iff (rst)
      (claim_tx_state == fomc_pkg::TX_IDLE && claim_req)
      |=> claim_tx_state == fomc_pkg::TX_CLAIM)
      else $error("software claim not honoured");
   addr_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
      ##1 use_long_addr == $past(o_la))
      else $error("wrong claim address width");
   err_count_a: assert property (@(posedge ref_clk) disable iff (rst)
      inc_err |=> error_indicator_counter
                  == $past(error_indicator_counter) + fomc_pkg::CNT_ONE)
      else $error("error counter missed increment");
   ext_match_a: assert property (@(posedge ref_clk) disable iff (rst)
      (o_em && ea_lvl) |=> tx_addr_recognized_ind)
      else $error("external match not shown");
   strip_iso_a: assert property (@(posedge ref_clk) disable iff (rst)
      isolated |=> strip_all)
      else $error("isolated station repeats frames");
endmodule : fomc_option_control

// >>> core/fomc_pkg.sv
// shared constants and carrier types for the ring option control block
package fomc_pkg;
   // option register bit positions
   localparam int OPT_SHORT_ADDR = 0;
   localparam int OPT_LONG_ADDR = 1;
   localparam int OPT_TOKEN_REL_INH = 2;
   localparam int OPT_RECOVERY_INH = 3;
   localparam int OPT_REPEAT_INH = 4;
   localparam int OPT_IMPL_CRC = 5;
   localparam int OPT_EXT_MATCH = 6;
   localparam int OPT_TOKEN_CAP_INH = 7;
   localparam logic [7:0] OPTION_RESET = 8'h00;
   localparam logic [1:0] FF_IMPLEMENTER = 2'h2;
   localparam logic [15:0] CNT_ONE = 16'h0001;

   // transmitter states
   typedef enum logic [6:0] {
      TX_IDLE = 7'h01,
      TX_REPEAT = 7'h02,
      TX_DATA = 7'h04,
      TX_ISSUE_TOKEN = 7'h08,
      TX_CLAIM = 7'h10,
      TX_BEACON = 7'h20,
      TX_VOID = 7'h40
   } fomc_tx_state_t;

   // events reported by the receiver side of the ring engine
   typedef struct packed {
      logic token_rx;
      logic mac_frame_rx;
      logic lower_claim_rx;
      logic my_beacon_rx;
      logic higher_claim_rx;
      logic beacon_rx;
      logic my_claim_won;
      logic recovery_required;
      logic ring_operational;
   } fomc_rx_evt_t;

   // transmit side requests
   typedef struct packed {
      logic token_usable;
      logic data_pending;
      logic void_wanted;
      logic immediate_req;
      logic sa_transparency;
      logic frame_done;
      logic opportunity_done;
      logic immediate_done;
   } fomc_tx_req_t;

   // frame status inputs for one received frame
   typedef struct packed {
      logic frame_end;
      logic [1:0] frame_format_bits;
      logic crc_good;
      logic rx_error_ind;
      logic internal_match;
      logic internal_copied;
   } fomc_frame_t;
endpackage : fomc_pkg
